// *** src/irq_map_defs.svh ***
/*
 * offsets, field positions, reset values and timing counts for the
 * interrupt pin map and filter configuration block.
 * assumes a 200 MHz system clock and word-indexed register offsets.
 */
`ifndef IRQ_MAP_DEFS_SVH
`define IRQ_MAP_DEFS_SVH

// register indices, byte address is four times the index
`define FIRST_MAP_IDX     8'h2A
`define SECOND_MAP_IDX    8'h2B
`define FILTER_CFG_IDX    8'h2C
`define TIMEBASE_CFG_IDX  8'h2D
`define IRQ_STATUS_IDX    8'h30
`define IRQ_CLEAR_IDX     8'h31
`define IRQ_ENABLE_IDX    8'h32
`define EVENT_LEVEL_IDX   8'h33

// map register fields
`define MAP_POL_BIT       3'd7
`define MAP_EVT_MSB       3'd6
`define NUM_EVENTS        7

// event bit positions
`define EVT_AWAKE         3'd6
`define EVT_INACTIVITY    3'd5
`define EVT_ACTIVITY      3'd4
`define EVT_Q_OVERRUN     3'd3
`define EVT_Q_WATERMARK   3'd2
`define EVT_Q_READY       3'd1
`define EVT_DATA_READY    3'd0

// filter register fields
`define FLT_RANGE_MSB     3'd7
`define FLT_RANGE_LSB     3'd6
`define FLT_NARROW_BIT    3'd4
`define FLT_EXT_TRIG_BIT  3'd3
`define FLT_RATE_MSB      3'd2
`define FLT_RATE_LSB      3'd0
`define TIMEBASE_BIT      3'd6

// reset values
`define MAP_RST           8'h00
`define FILTER_RST        8'h13
`define TIMEBASE_RST      8'h00
`define IRQ_EN_RST        7'h00

// timing
`define CLK_PERIOD_NS     5
`define SLOW_RATE_DHZ     125
`define RATE_STEPS_MAX    3'd5
`define SLOW_RATE_CYC     (64'd10_000_000_000 / (`SLOW_RATE_DHZ * `CLK_PERIOD_NS))
`define EXT_TIMEBASE_SEL_MAX_HZ    51200
`define SLOW_RATE_EDGES   ((`EXT_TIMEBASE_SEL_MAX_HZ * 10) / `SLOW_RATE_DHZ)

`endif

// *** src/irq_map_pkg.sv ***
/*
 * types shared by the interrupt pin map and filter configuration block.
 * assumes nothing of its surroundings.
 */
package irq_map_pkg;

    typedef enum logic [1:0] {
        RANGE_2G,
        RANGE_4G,
        RANGE_8G
    } range_t;

    typedef enum logic [2:0] {
        RATE_12P5,
        RATE_25,
        RATE_50,
        RATE_100,
        RATE_200,
        RATE_400
    } rate_t;

    typedef enum logic [1:0] {
        TB_INTERNAL,
        TB_EXT_CLOCK,
        TB_EXT_TRIGGER
    } timebase_t;

endpackage

// *** src/irq_pin_driver.sv ***
/*
 * one interrupt pin: event select, or, polarity and release.
 * assumes event levels synchronous to i_clk and an external keeper on the pin.
 */
`timescale 1ns/1ps
`include "irq_map_defs.svh"

module irq_pin_driver (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_map,
    input  wire logic [6:0] i_event,
    input  wire logic       i_as_input,
    output logic            o_pin_out,
    output logic            o_pin_oe
);

    logic any_mapped;
    logic active;

    assign any_mapped = |i_map[`MAP_EVT_MSB:0];
    assign active     = |(i_map[`MAP_EVT_MSB:0] & i_event);

    // last level is kept while released, matching the keeper
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pin_out <= 1'b0;
        end else if (any_mapped && !i_as_input) begin
            o_pin_out <= active ^ i_map[`MAP_POL_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pin_oe <= 1'b0;
        end else begin
            o_pin_oe <= any_mapped && !i_as_input;
        end
    end

endmodule // irq_pin_driver

// *** src/sample_timer.sv ***
/*
 * conversion strobe from the internal rate, an external timebase or a trigger.
 * assumes pin inputs synchronous to i_clk.
 */
`timescale 1ns/1ps
`include "irq_map_defs.svh"

module sample_timer #(
    parameter int unsigned CNT_W      = 32,
    parameter int unsigned SLOW_CYC   = 16_000_000,
    parameter int unsigned SLOW_EDGES = 4096
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic [2:0] i_rate_steps,
    input  wire logic       i_ext_trigger_sel,
    input  wire logic       i_ext_timebase_sel,
    input  wire logic       i_trigger_in,
    input  wire logic       i_timebase_in,
    output logic            o_tick
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] period;
    logic             trig_prev_ff;
    logic             tb_prev_ff;
    logic             step;

    assign period = i_ext_timebase_sel ? (CNT_W'(SLOW_EDGES) >> i_rate_steps)
                                       : (CNT_W'(SLOW_CYC) >> i_rate_steps);
    assign step   = i_ext_timebase_sel ? (i_timebase_in && !tb_prev_ff) : 1'b1;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            trig_prev_ff <= 1'b0;
            tb_prev_ff   <= 1'b0;
        end else begin
            trig_prev_ff <= i_trigger_in;
            tb_prev_ff   <= i_timebase_in;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_ff <= '0;
        end else if (i_ext_trigger_sel) begin
            cnt_ff <= '0;
        end else if (step) begin
            cnt_ff <= (cnt_ff >= period - CNT_W'(1)) ? '0 : cnt_ff + CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_tick <= 1'b0;
        end else if (i_ext_trigger_sel) begin
            o_tick <= i_trigger_in && !trig_prev_ff;
        end else begin
            o_tick <= step && (cnt_ff >= period - CNT_W'(1));
        end
    end

endmodule // sample_timer

// *** src/irq_pin_map_and_filter_cfg.sv ***
/*
 * interrupt pin map, filter and sample configuration, apb register slave,
 * sticky event interrupt and the conversion strobe.
 * assumes an apb master on i_clk, event levels synchronous to i_clk and
 * pin keepers plus pin resolution outside the block.
 */
`timescale 1ns/1ps
`include "irq_map_defs.svh"

module irq_pin_map_and_filter_cfg #(
    parameter int unsigned ADDR_W     = 12,
    parameter int unsigned SLOW_CYC   = 32'(`SLOW_RATE_CYC),
    parameter int unsigned SLOW_EDGES = `SLOW_RATE_EDGES
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    input  wire logic [6:0]        i_event,
    input  wire logic              i_first_irq_pin_in,
    output logic                   o_first_irq_pin_out,
    output logic                   o_first_irq_pin_oe,
    input  wire logic              i_second_irq_pin_in,
    output logic                   o_second_irq_pin_out,
    output logic                   o_second_irq_pin_oe,
    output logic                   o_irq,
    output logic                   o_sample_tick,
    output irq_map_pkg::range_t    o_range,
    output irq_map_pkg::rate_t     o_sample_rate_sel,
    output logic                   o_narrow_filter_sel,
    output irq_map_pkg::timebase_t o_timebase
);

    logic [7:0] first_map_ff;
    logic [7:0] second_map_ff;
    logic [7:0] filter_ff;
    logic [7:0] timebase_ff;
    logic [6:0] irq_status_ff;
    logic [6:0] irq_enable_ff;
    logic [6:0] event_prev_ff;
    logic [6:0] event_rise;
    logic [6:0] irq_clear;
    logic [6:0] nxt_irq_status;
    logic [7:0] acc_idx;
    logic       setup;
    logic       wr_en;
    logic [7:0] wr_byte;
    logic [31:0] rd_word;
    logic       ext_trigger_sel;
    logic       ext_timebase_sel;
    logic [2:0] rate_steps;

    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
        return addr[9:2];
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        case (idx)
            `FIRST_MAP_IDX, `SECOND_MAP_IDX, `FILTER_CFG_IDX, `TIMEBASE_CFG_IDX,
            `IRQ_STATUS_IDX, `IRQ_CLEAR_IDX, `IRQ_ENABLE_IDX, `EVENT_LEVEL_IDX: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction

    function automatic irq_map_pkg::range_t range_of(input logic [1:0] f);
        case (f)
            2'b00:   return irq_map_pkg::RANGE_2G;
            2'b01:   return irq_map_pkg::RANGE_4G;
            default: return irq_map_pkg::RANGE_8G;
        endcase
    endfunction

    function automatic irq_map_pkg::rate_t rate_of(input logic [2:0] f);
        case (f)
            3'b000:  return irq_map_pkg::RATE_12P5;
            3'b001:  return irq_map_pkg::RATE_25;
            3'b010:  return irq_map_pkg::RATE_50;
            3'b011:  return irq_map_pkg::RATE_100;
            3'b100:  return irq_map_pkg::RATE_200;
            default: return irq_map_pkg::RATE_400;
        endcase
    endfunction

    assign acc_idx          = word_index(i_paddr);
    assign setup            = i_psel && !i_penable;
    assign wr_en            = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0];
    assign wr_byte          = i_pwdata[7:0];
    assign ext_trigger_sel  = filter_ff[`FLT_EXT_TRIG_BIT];
    assign ext_timebase_sel = timebase_ff[`TIMEBASE_BIT];
    assign rate_steps       = (filter_ff[`FLT_RATE_MSB:`FLT_RATE_LSB] > `RATE_STEPS_MAX)
                              ? `RATE_STEPS_MAX : filter_ff[`FLT_RATE_MSB:`FLT_RATE_LSB];

    // apb answer: ready in the first access cycle, data and error set at setup
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= setup;
            o_pslverr <= setup && !is_mapped(acc_idx);
            o_prdata  <= (setup && !i_pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (acc_idx)
            `FIRST_MAP_IDX:    rd_word[7:0] = first_map_ff;
            `SECOND_MAP_IDX:   rd_word[7:0] = second_map_ff;
            `FILTER_CFG_IDX:   rd_word[7:0] = filter_ff;
            `TIMEBASE_CFG_IDX: rd_word[7:0] = timebase_ff;
            `IRQ_STATUS_IDX:   rd_word[6:0] = irq_status_ff;
            `IRQ_ENABLE_IDX:   rd_word[6:0] = irq_enable_ff;
            `EVENT_LEVEL_IDX:  rd_word[6:0] = i_event;
            default:           rd_word = 32'h0000_0000;
        endcase
    end

    // configuration registers
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            first_map_ff  <= `MAP_RST;
            second_map_ff <= `MAP_RST;
        end else if (wr_en) begin
            if (acc_idx == `FIRST_MAP_IDX) begin
                first_map_ff <= wr_byte;
            end
            if (acc_idx == `SECOND_MAP_IDX) begin
                second_map_ff <= wr_byte;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            filter_ff   <= `FILTER_RST;
            timebase_ff <= `TIMEBASE_RST;
        end else if (wr_en) begin
            if (acc_idx == `FILTER_CFG_IDX) begin
                filter_ff <= wr_byte;
            end
            if (acc_idx == `TIMEBASE_CFG_IDX) begin
                timebase_ff <= wr_byte & (8'h01 << `TIMEBASE_BIT);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_enable_ff <= `IRQ_EN_RST;
        end else if (wr_en && acc_idx == `IRQ_ENABLE_IDX) begin
            irq_enable_ff <= wr_byte[6:0];
        end
    end

    // sticky event flags, a new event wins over a clear in the same cycle
    assign event_rise = i_event & ~event_prev_ff;
    assign irq_clear  = (wr_en && acc_idx == `IRQ_CLEAR_IDX) ? wr_byte[6:0] : 7'h00;

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_EVENTS; gi++) begin : g_sticky
            assign nxt_irq_status[gi] = event_rise[gi] || (irq_status_ff[gi] && !irq_clear[gi]);
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            event_prev_ff <= 7'h00;
            irq_status_ff <= 7'h00;
            o_irq         <= 1'b0;
        end else begin
            event_prev_ff <= i_event;
            irq_status_ff <= nxt_irq_status;
            o_irq         <= |(nxt_irq_status & irq_enable_ff);
        end
    end

    // decoded configuration outputs
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_range             <= irq_map_pkg::RANGE_2G;
            o_sample_rate_sel   <= irq_map_pkg::RATE_100;
            o_narrow_filter_sel <= 1'b1;
            o_timebase          <= irq_map_pkg::TB_INTERNAL;
        end else begin
            o_range             <= range_of(filter_ff[`FLT_RANGE_MSB:`FLT_RANGE_LSB]);
            o_sample_rate_sel   <= rate_of(filter_ff[`FLT_RATE_MSB:`FLT_RATE_LSB]);
            o_narrow_filter_sel <= filter_ff[`FLT_NARROW_BIT];
            if (ext_trigger_sel) begin
                o_timebase <= irq_map_pkg::TB_EXT_TRIGGER;
            end else if (ext_timebase_sel) begin
                o_timebase <= irq_map_pkg::TB_EXT_CLOCK;
            end else begin
                o_timebase <= irq_map_pkg::TB_INTERNAL;
            end
        end
    end

    irq_pin_driver u_first_pin (
        .i_clk      (i_clk),
        .i_rst_b    (i_rst_b),
        .i_map      (first_map_ff),
        .i_event    (i_event),
        .i_as_input (ext_timebase_sel),
        .o_pin_out  (o_first_irq_pin_out),
        .o_pin_oe   (o_first_irq_pin_oe)
    );

    irq_pin_driver u_second_pin (
        .i_clk      (i_clk),
        .i_rst_b    (i_rst_b),
        .i_map      (second_map_ff),
        .i_event    (i_event),
        .i_as_input (ext_trigger_sel),
        .o_pin_out  (o_second_irq_pin_out),
        .o_pin_oe   (o_second_irq_pin_oe)
    );

    sample_timer #(
        .CNT_W      (32),
        .SLOW_CYC   (SLOW_CYC),
        .SLOW_EDGES (SLOW_EDGES)
    ) u_timer (
        .i_clk              (i_clk),
        .i_rst_b            (i_rst_b),
        .i_rate_steps       (rate_steps),
        .i_ext_trigger_sel  (ext_trigger_sel),
        .i_ext_timebase_sel (ext_timebase_sel),
        .i_trigger_in       (i_second_irq_pin_in),
        .i_timebase_in      (i_first_irq_pin_in),
        .o_tick             (o_sample_tick)
    );

    // checks
    a_first_pin_level: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_first_irq_pin_oe |-> o_first_irq_pin_out ==
            ($past(|(first_map_ff[6:0] & i_event)) ^ $past(first_map_ff[7])))
        else $error("first pin level differs from mapped events and polarity");

    a_active_low_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (first_map_ff == 8'h81 && !i_event[0] && !ext_timebase_sel) |=> o_first_irq_pin_out)
        else $error("active low pin not high while idle");

    a_second_pin_level: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_second_irq_pin_oe |-> o_second_irq_pin_out ==
            ($past(|(second_map_ff[6:0] & i_event)) ^ $past(second_map_ff[7])))
        else $error("second pin level differs from mapped events and polarity");

    a_unmapped_float: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (first_map_ff[6:0] == 7'h00) |=> !o_first_irq_pin_oe && $stable(o_first_irq_pin_out))
        else $error("unmapped first pin is driven or changed level");

    a_trigger_frees_pin: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ext_trigger_sel |=> !o_second_irq_pin_oe)
        else $error("second pin driven while used as trigger input");

    a_timebase_frees_pin: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ext_timebase_sel |=> !o_first_irq_pin_oe)
        else $error("first pin driven while used as timebase input");

    a_trigger_tick: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (ext_trigger_sel && $rose(i_second_irq_pin_in)) |=> o_sample_tick)
        else $error("trigger edge gave no conversion strobe");

    a_bw_follows: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ##1 o_narrow_filter_sel == $past(filter_ff[4]))
        else $error("filter width output does not follow its bit");

    a_range_decode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ($past(filter_ff[7]) |-> o_range == irq_map_pkg::RANGE_8G) and
        ($past(filter_ff[7:6]) == 2'b01 |-> o_range == irq_map_pkg::RANGE_4G))
        else $error("range decode wrong");

    a_rate_decode: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        ($past(filter_ff[2:0]) >= 3'd5) |-> o_sample_rate_sel == irq_map_pkg::RATE_400)
        else $error("top rate codes not decoded as fastest rate");

    a_reset_values: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !$past(i_rst_b) |-> first_map_ff == 8'h00 && filter_ff == 8'h13 && !o_first_irq_pin_oe)
        else $error("reset values wrong");

    a_irq_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (event_rise[0] && irq_enable_ff[0]) |=> o_irq && irq_status_ff[0])
        else $error("enabled event did not raise the interrupt");

    c_both_pins_driven: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        o_first_irq_pin_oe && o_second_irq_pin_oe && o_first_irq_pin_out);
    c_trigger_strobe: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        ext_trigger_sel && o_sample_tick);
    c_irq_cleared: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        o_irq ##1 !o_irq);

endmodule // irq_pin_map_and_filter_cfg

// *** tb/irq_host_model.sv ***
/*
 * host side of the two interrupt pins: keepers and host drive.
 * assumes oe and out come from the device; the host drives only a released pin.
 */
`timescale 1ns/1ps

module irq_host_model (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_out1,
    input  wire logic i_oe1,
    input  wire logic i_drv1,
    input  wire logic i_val1,
    input  wire logic i_out2,
    input  wire logic i_oe2,
    input  wire logic i_drv2,
    input  wire logic i_val2,
    output logic      o_pin1,
    output logic      o_pin2
);
    logic keep1_ff;
    logic keep2_ff;

    // keeper holds the last level while nobody drives
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            keep1_ff <= 1'b0;
            keep2_ff <= 1'b0;
        end else begin
            keep1_ff <= o_pin1;
            keep2_ff <= o_pin2;
        end
    end

    // host drives timebase and trigger only on a released pin
    always_comb o_pin1 = i_oe1 ? i_out1 : (i_drv1 ? i_val1 : keep1_ff);
    always_comb o_pin2 = i_oe2 ? i_out2 : (i_drv2 ? i_val2 : keep2_ff);
endmodule // irq_host_model

// *** tb/tb.sv ***
/*
 * self-checking bench: apb register access, pin map, filter and timing.
 * assumes the block answers one apb cycle after setup and small timing counts.
 */
`timescale 1ns/1ps

module tb;
    logic                   clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]            paddr = 0;
    logic [31:0]            pwdata = 0, prdata, rd;
    logic [3:0]             pstrb = 4'hF;
    logic [6:0]             ev = 0;
    logic                   drv1 = 0, val1 = 0, drv2 = 0, val2 = 0;
    logic                   pready, pslverr, er, pin1, pin2, out1, oe1, out2, oe2;
    logic                   irq, tick, narrow;
    irq_map_pkg::range_t    rng;
    irq_map_pkg::rate_t     rate;
    irq_map_pkg::timebase_t tbase;
    int                     err_total = 0, check_count = 0, tick_cnt = 0, c0, r;

    irq_pin_map_and_filter_cfg #(.SLOW_CYC(64), .SLOW_EDGES(64)) irq_pin_map_and_filter_cfg_i (
        .i_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_event(ev),
        .i_first_irq_pin_in(pin1), .o_first_irq_pin_out(out1), .o_first_irq_pin_oe(oe1),
        .i_second_irq_pin_in(pin2), .o_second_irq_pin_out(out2), .o_second_irq_pin_oe(oe2),
        .o_irq(irq), .o_sample_tick(tick), .o_range(rng), .o_sample_rate_sel(rate),
        .o_narrow_filter_sel(narrow), .o_timebase(tbase));

    irq_host_model irq_host_model_i (
        .i_clk(clk), .i_rst_b(rst_b), .i_out1(out1), .i_oe1(oe1), .i_drv1(drv1),
        .i_val1(val1), .i_out2(out2), .i_oe2(oe2), .i_drv2(drv2), .i_val2(val2),
        .o_pin1(pin1), .o_pin2(pin2));

    initial forever #2.5 clk = ~clk;
    always @(posedge clk) if (tick === 1'b1) tick_cnt <= tick_cnt + 1;

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= {2'b00, idx, 2'b00}; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task rdc(input string nm, input logic [7:0] idx, input logic [31:0] e);
        apb(0, idx, 0);
        chk(nm, e, rd);
    endtask

    task setev(input logic [6:0] e);
        ev <= e;
        repeat (3) @(posedge clk);
    endtask

    task ticks(input int n, input logic [31:0] e);
        c0 = tick_cnt;
        repeat (n) @(posedge clk);
        chk("ticks", e, 32'(tick_cnt - c0));
    endtask

    task pulse1(input int n);
        repeat (n) begin
            val1 <= 1; repeat (2) @(posedge clk);
            val1 <= 0; repeat (2) @(posedge clk);
        end
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #100_000;
        err_total++;
        $display("FAIL watchdog expected finish seen timeout");
        print_verdict;
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1;
        rdc("map1", 8'h2A, 0);
        rdc("map2", 8'h2B, 0);
        rdc("filter", 8'h2C, 32'h13);
        chk("range", 0, 32'(rng));
        chk("rate", 3, 32'(rate));
        chk("narrow", 1, narrow);
        chk("pin1 oe", 0, oe1);
        apb(0, 8'h20, 0);
        chk("slverr", 1, er);
        ticks(64, 8);
        $display("test reset done");
        apb(1, 8'h2B, 32'h7F);
        for (int k = 0; k < 7; k++) begin
            apb(1, 8'h2A, 32'h1 << k);
            setev(7'h1 << k);
            chk("pin1 on", 3, {oe1, out1});
            chk("pin2 or", 3, {oe2, out2});
            setev(0);
            chk("pin1 off", 2, {oe1, out1});
            apb(1, 8'h2A, 32'h80 | (32'h1 << k));
            setev(7'h1 << k);
            chk("pin1 low", 2, {oe1, out1});
        end
        apb(1, 8'h2B, 0);
        setev(7'h40);
        chk("pin2 rel", 1, {oe2, out2});
        chk("pin2 keep", 1, pin2);
        $display("test pin map done");
        for (r = 0; r < 8; r++) begin
            apb(1, 8'h2C, {24'd0, 2'(r), 3'b000, 3'(r)});
            rdc("filter rb", 8'h2C, {24'd0, 2'(r), 3'b000, 3'(r)});
            chk("range", (r & 2) ? 2 : r & 3, 32'(rng));
            chk("rate", (r > 5) ? 5 : r, 32'(rate));
            chk("narrow", 0, narrow);
            repeat (70) @(posedge clk);
            ticks(128, 2 << ((r > 5) ? 5 : r));
        end
        $display("test filter done");
        apb(1, 8'h2B, 32'h40);
        apb(1, 8'h2C, 32'h08);
        drv2 <= 1;
        val2 <= 0;
        repeat (3) @(posedge clk);
        chk("pin2 oe", 0, oe2);
        chk("timebase", 2, 32'(tbase));
        ticks(20, 0);
        val2 <= 1;
        ticks(6, 1);
        apb(1, 8'h2C, 32'h13);
        apb(1, 8'h2D, 32'h40);
        drv1 <= 1;
        repeat (3) @(posedge clk);
        chk("pin1 oe", 0, oe1);
        chk("timebase", 1, 32'(tbase));
        pulse1(4);
        repeat (4) @(posedge clk);
        c0 = tick_cnt;
        pulse1(64);
        repeat (4) @(posedge clk);
        chk("ext ticks", 8, 32'(tick_cnt - c0));
        apb(1, 8'h2D, 0);
        $display("test timing done");
        setev(0);
        apb(1, 8'h31, 32'h7F);
        apb(1, 8'h32, 32'h01);
        setev(7'h02);
        chk("irq masked", 0, irq);
        rdc("status", 8'h30, 32'h02);
        setev(7'h03);
        chk("irq set", 1, irq);
        rdc("status", 8'h30, 32'h03);
        apb(1, 8'h31, 32'h01);
        repeat (2) @(posedge clk);
        chk("irq clr", 0, irq);
        rdc("status", 8'h30, 32'h02);
        rdc("event lvl", 8'h33, 32'h03);
        rdc("irq en", 8'h32, 32'h01);
        $display("test interrupt done");
        setev(0);
        rst_b <= 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        rdc("map1 rst", 8'h2A, 0);
        rdc("filter rst", 8'h2C, 32'h13);
        chk("pin1 oe rst", 0, oe1);
        chk("narrow rst", 1, narrow);
        $display("test second reset done");
        print_verdict;
    end
endmodule // tb
